// ===== dv/ipf_cam_model.sv
/*
 * Capture front end model: offers one raster frame of grey pixels to the chain.
 * Assumes inReady is sampled on the rising edge of sys_clk and a frame is N pixels.
 */
`timescale 1ns/1ns

module ipf_cam_model #(
   parameter int N = 20
) (
   input wire logic sys_clk,
   input wire logic inReady,
   output logic inValid,
   output logic [7:0] inData
);

   // Idle values at time zero.
   initial
   begin
      inValid = 1'b0;
      inData = 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Each pixel is held until an edge sees inReady high; gap idle cycles before each pixel
   // model a slow camera. Idle data is inverted every cycle so a stale value never matches.
   task automatic send_frame(input int pix[N], input int gap);
      int i;
      int left;
      logic taken;
      i = 0;
      left = gap;
      while (i < N)
      begin
         if (left > 0)
         begin
            inValid = 1'b0;
            inData = ~inData;
            left--;
         end
         else
         begin
            inValid = 1'b1;
            inData = 8'(pix[i]);
         end
         // Ready only changes on an edge, so its value now is what the next edge samples.
         taken = inValid && inReady;
         @(posedge sys_clk);
         #1;
         if (taken)
         begin
            i++;
            left = gap;
         end
      end
      inValid = 1'b0;
      inData = ~inData;
   endtask : send_frame

endmodule : ipf_cam_model

// ===== dv/testbench.sv
/*
 * Self-checking bench of the filter chain: a reference model predicts every output frame.
 * Assumes a 5x4 frame, random output back-pressure and configuration sampled once per frame.
 */
`timescale 1ns/1ns

module testbench;

   localparam int W = 5;
   localparam int H = 4;
   localparam int N = W * H;
   localparam int LIMIT = 90000;
   typedef int ipf_frame_t[N];

   logic sys_clk;
   logic rst;
   logic [1:0] geoMode;
   logic [4:0][3:0] slotFilter;
   logic [4:0][1:0] slotSize;
   logic [4:0][1:0] slotGain;
   logic inValid;
   logic [7:0] inData;
   logic inReady;
   logic outReady;
   logic outValid;
   logic [7:0] outData;
   logic outLast;
   logic busy;
   logic [8:0] expQ[$];
   int nFail = 0;
   int checksDone = 0;
   int cycles = 0;
   int frameNo = 0;
   int seed = 32'hf715a918;

   ipf_filter_chain #(.W(W), .H(H)) uut (.sys_clk(sys_clk), .rst(rst), .geoMode(geoMode),
      .slotFilter(slotFilter), .slotSize(slotSize), .slotGain(slotGain), .inValid(inValid),
      .inData(inData), .inReady(inReady), .outValid(outValid), .outData(outData),
      .outLast(outLast), .busy(busy), .outReady(outReady));

   ipf_cam_model #(.N(N)) cam (.sys_clk(sys_clk), .inReady(inReady), .inValid(inValid),
      .inData(inData));

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Comparison and verdict helpers.
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checksDone++;
      if (seen !== exp)
      begin
         nFail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      if (nFail == 0 && checksDone > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : final_report

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Reference model. Coordinates are clamped so borders replicate edge pixels.
   function automatic int at(ipf_frame_t f, int x, int y);
      x = (x < 0) ? 0 : ((x > W - 1) ? W - 1 : x);
      y = (y < 0) ? 0 : ((y > H - 1) ? H - 1 : y);
      return f[y * W + x];
   endfunction : at

   function automatic int isq(int v);
      int r;
      r = 0;
      while ((r + 1) * (r + 1) <= v)
         r++;
      return r;
   endfunction : isq

   function automatic ipf_frame_t geo(ipf_frame_t f, int m);
      ipf_frame_t o;
      for (int y = 0; y < H; y++)
         for (int x = 0; x < W; x++)
            o[y * W + x] = at(f, (m == 1 || m == 3) ? W - 1 - x : x,
                              (m == 1 || m == 2) ? H - 1 - y : y);
      return o;
   endfunction : geo

   // One slot over a whole frame; Sobel always uses only the inner 3x3 of the window.
   function automatic ipf_frame_t run_slot(ipf_frame_t f, int flt, int sz, int gn);
      ipf_frame_t o;
      int v[$];
      int b[5];
      int r, n, p, mn, mx, s, s2, gs, gx, gy, c;
      if (sz == 0)
         return f;
      r = (sz == 1) ? 1 : 2;
      n = (2 * r + 1) * (2 * r + 1);
      b = '{1, 4, 6, 4, 1};
      if (r == 1)
         b = '{1, 2, 1, 0, 0};
      for (int y = 0; y < H; y++)
         for (int x = 0; x < W; x++)
         begin
            v = {};
            mn = 255;
            mx = 0;
            s = 0;
            s2 = 0;
            gs = 0;
            gx = 0;
            gy = 0;
            for (int dy = -r; dy <= r; dy++)
               for (int dx = -r; dx <= r; dx++)
               begin
                  p = at(f, x + dx, y + dy);
                  v.push_back(p);
                  mn = (p < mn) ? p : mn;
                  mx = (p > mx) ? p : mx;
                  s += p;
                  s2 += p * p;
                  gs += b[dx + r] * b[dy + r] * p;
                  if (dx * dx <= 1 && dy * dy <= 1)
                  begin
                     gx += dx * (2 - dy * dy) * p;
                     gy += dy * (2 - dx * dx) * p;
                  end
               end
            v.sort();
            c = f[y * W + x];
            case (flt)
               0: o[y * W + x] = gs >> ((r == 1) ? 4 : 8);
               1: o[y * W + x] = mn;
               2: o[y * W + x] = mx;
               3: o[y * W + x] = v[n / 2];
               4: o[y * W + x] = s / n;
               5: o[y * W + x] = mx - mn;
               6: o[y * W + x] = isq((n * s2 - s * s) / (n * n));
               7: o[y * W + x] = (isq(gx * gx + gy * gy) > 255) ? 255 : isq(gx * gx + gy * gy);
               8: o[y * W + x] = ((c << (gn + 1)) > 255) ? 255 : (c << (gn + 1));
               9: o[y * W + x] = 255 - c;
               default: o[y * W + x] = c;
            endcase
         end
      return o;
   endfunction : run_slot

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Set the configuration while the chain is busy, note the expected frame, send the frame.
   // Odd frames use small pixel values so gain has unsaturated results too.
   task automatic run_frame(input logic [19:0] fv, input logic [9:0] sv, input logic [9:0] gv,
                            input logic [1:0] m, input int gap);
      ipf_frame_t pix;
      ipf_frame_t e;
      slotFilter = fv;
      slotSize = sv;
      slotGain = gv;
      geoMode = m;
      rst = 1'b0;
      for (int i = 0; i < N; i++)
         pix[i] = $random(seed) & ((frameNo % 2) ? 32'h1f : 32'hff);
      e = geo(pix, m);
      for (int i = 0; i < 5; i++)
         e = run_slot(e, fv[i * 4 +: 4], sv[i * 2 +: 2], gv[i * 2 +: 2]);
      for (int i = 0; i < N; i++)
         expQ.push_back({i == N - 1, 8'(e[i])});
      frameNo++;
      cam.send_frame(pix, gap);
      check("inReady after frame", {7'h0, inReady}, 8'h00);
      check("busy after frame", {7'h0, busy}, 8'h01);
   endtask : run_frame

   // Clock of 20 ns.
   initial
   begin
      sys_clk = 1'b0;
      forever
         #10 sys_clk = ~sys_clk;
   end

   // Random back-pressure, changed just after each edge so stalls exercise the output hold.
   always @(posedge sys_clk)
   begin
      #1;
      outReady = rst || (($random(seed) & 32'h3) != 32'h0);
   end

   // Output watcher: every accepted pixel takes the oldest expected note. It looks on the
   // falling edge, where outputs and ready are settled for the next rising edge.
   always @(negedge sys_clk)
   begin
      if (!rst && outValid === 1'b1 && outReady === 1'b1)
      begin
         if (expQ.size() == 0)
            check("unexpected pixel", 8'h01, 8'h00);
         else
         begin
            check("outData", outData, expQ[0][7:0]);
            check("outLast", {7'h0, outLast}, {7'h0, expQ[0][8]});
            void'(expQ.pop_front());
         end
      end
   end

   // Hang guard.
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         nFail++;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Main sequence: every filter code in one kernel size (3x3 for even codes, 5x5 for odd), every
   // rearrangement with a different gain, a mixed chain, all slots off, then random configurations.
   initial
   begin
      logic [4:0][3:0] fv;
      logic [4:0][1:0] sv;
      logic [4:0][1:0] gv;
      rst = 1'b1;
      geoMode = 2'h0;
      slotFilter = '0;
      slotSize = '0;
      slotGain = '0;
      repeat (12) @(posedge sys_clk);
      #1;
      for (int k = 0; k < 10; k++)
      begin
         fv = 20'($random(seed));
         sv = '0;
         gv = 10'($random(seed));
         fv[k % 5] = 4'(k);
         sv[k % 5] = 2'((k % 2) + 1);
         run_frame(fv, sv, gv, 2'h0, k % 3);
      end
      for (int k = 0; k < 4; k++)
      begin
         fv = 20'($random(seed));
         sv = '0;
         gv = '0;
         fv[4] = 4'h8;
         sv[4] = 2'h3;
         gv[4] = 2'(k);
         run_frame(fv, sv, gv, 2'(k), 1);
      end
      run_frame({4'hc, 4'h4, 4'h9, 4'h2, 4'h1}, 10'h155, 10'h0, 2'h1, 0);
      run_frame({4'h1, 4'h2, 4'h7, 4'h5, 4'h0}, 10'h000, 10'h0, 2'h0, 2);
      for (int k = 0; k < 3; k++)
         run_frame(20'($random(seed)), 10'($random(seed)), 10'($random(seed)),
                   2'($random(seed)), k);
      for (int i = 0; i < 30000 && expQ.size() > 0; i++)
         @(posedge sys_clk);
      repeat (5) @(posedge sys_clk);
      check("pixels left", 8'(expQ.size()), 8'h00);
      final_report();
   end

endmodule : testbench

// ===== src/ipf_filter_chain.sv
/*
 * Frame-based pre-processing chain: one rearrangement stage applied on
 * capture, five filter slots run one after another over ping-pong frame
 * memories, then raster output. Assumes raster-order input pixels and
 * configuration held stable from the IDLE cycle until the frame starts.
 */
`timescale 1ns/1ns

// Operation
// - Five filter slots plus one rearrangement stage, each configured independently.
// - Output reads the last active slot's result, or the capture when no slot is active.
// - Active slots run in order first to last, each on previous output.
// - Each slot has a kernel size; size off passes pixels unchanged.
// - Rearrangement offers rotate 180, vertical mirror or horizontal mirror.
// - Erosion outputs the minimum grey level of the square neighbourhood.
// - Dilation outputs the maximum grey level of the square neighbourhood.
// - Median mode outputs the median of the neighbourhood values.
// - Mean mode outputs the average of the neighbourhood values.
// - Range mode outputs neighbourhood maximum minus minimum.
// - Deviation mode outputs the standard deviation of the neighbourhood.
// - Edge mode outputs the Sobel gradient magnitude.
// - Smoothing mode convolves with a Gaussian mask of the kernel size.
// - Gain mode multiplies by 2, 4, 8 or 16, saturating at 255.
module ipf_filter_chain #(
   parameter int W = 16,
   parameter int H = 16
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] geoMode,
   input wire logic [4:0][3:0] slotFilter,
   input wire logic [4:0][1:0] slotSize,
   input wire logic [4:0][1:0] slotGain,
   input wire logic inValid,
   input wire logic [7:0] inData,
   input wire logic outReady,
   output logic inReady,
   output logic outValid,
   output logic [7:0] outData,
   output logic outLast,
   output logic busy
);

   localparam int N = W * H;
   localparam int AW = $clog2(N);
   localparam int XW = $clog2(W);
   localparam int YW = $clog2(H);

   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_LOAD = 3'h1, S_SETUP = 3'h2, S_SWEEP = 3'h3,
      S_FINISH = 3'h4, S_ROOT = 3'h5, S_WRITE = 3'h6, S_UNLOAD = 3'h7
   } ipf_state_e;

   ipf_state_e stateQ;
   ipf_pkg::ipf_geo_e geoQ;
   ipf_pkg::ipf_filter_e flt;
   logic [4:0][3:0] cfgFltQ;
   logic [4:0][1:0] cfgSizeQ, cfgGainQ;
   logic [7:0] memA [N];
   logic [7:0] memB [N];
   logic [XW-1:0] xQ;
   logic [YW-1:0] yQ;
   logic signed [2:0] wxQ, wyQ, rad;
   logic [2:0] slotQ, medBitQ;
   logic bankQ, endQ, winEnd, lastPix, rootStart, rootDone;
   logic [7:0] p, mnQ, mxQ, ctrQ, medQ, resQ, resD, cand;
   logic [4:0] ltCntQ, cntNext;
   logic [12:0] sumQ;
   logic [20:0] sqQ;
   logic signed [11:0] gxQ, gyQ;
   logic [15:0] gsQ, rootVal;
   logic [31:0] radicand;
   logic [AW-1:0] pixAddr, rdAddr, loadAddr;
   int n;

   // Coordinate clamp; replicating border pixels keeps the frame size.
   function automatic int clampc(input int v, input int hi);
      return (v < 0) ? 0 : ((v > hi) ? hi : v);
   endfunction : clampc

   // One-dimensional binomial weight of the Gaussian mask.
   function automatic int binw(input int o, input int r);
      int a;
      a = (o < 0) ? -o : o;
      if (r == 1)
         return (a == 0) ? 2 : 1;
      return (a == 0) ? 6 : ((a == 1) ? 4 : 1);
   endfunction : binw

   ////////////////////////////////////////////////////////////////////////////
   // Per-slot decode and neighbourhood addressing.
   assign flt = ipf_pkg::ipf_filter_e'(cfgFltQ[slotQ]);
   assign rad = (cfgSizeQ[slotQ] == ipf_pkg::SIZE_3X3) ? 3'sd1 : 3'sd2;
   assign n = (rad == 3'sd1) ? 9 : 25;
   assign pixAddr = AW'(int'(yQ) * W + int'(xQ));
   assign rdAddr = AW'(clampc(int'(yQ) + int'(wyQ), H - 1) * W
                       + clampc(int'(xQ) + int'(wxQ), W - 1));
   assign p = bankQ ? memB[rdAddr] : memA[rdAddr];
   assign winEnd = (wxQ == rad) && (wyQ == rad);
   assign lastPix = (int'(xQ) == W - 1) && (int'(yQ) == H - 1);
   assign cand = medQ | (8'h01 << medBitQ);
   assign cntNext = ltCntQ + ((p < cand) ? 5'h01 : 5'h00);
   assign inReady = (stateQ == S_LOAD);
   assign busy = (stateQ != S_LOAD);
   assign rootStart = (stateQ == S_FINISH) &&
                      (flt == ipf_pkg::F_STDDEV || flt == ipf_pkg::F_SOBEL);

   // Rearrangement is done by writing the captured pixel to a mirrored address.
   always_comb
   begin
      int lx;
      int ly;
      lx = int'(xQ);
      ly = int'(yQ);
      if (geoQ == ipf_pkg::G_ROT180 || geoQ == ipf_pkg::G_FLIP)
         lx = W - 1 - lx;
      if (geoQ == ipf_pkg::G_ROT180 || geoQ == ipf_pkg::G_MIRROR)
         ly = H - 1 - ly;
      loadAddr = AW'(ly * W + lx);
   end

   // Result of the point and non-root window filters, and the root operand.
   always_comb
   begin
      int g;
      g = int'(ctrQ) << (int'(cfgGainQ[slotQ]) + 1);
      resD = ctrQ;
      radicand = 32'(int'(gxQ) * int'(gxQ) + int'(gyQ) * int'(gyQ));
      if (flt == ipf_pkg::F_STDDEV)
         radicand = 32'((n * int'(sqQ) - int'(sumQ) * int'(sumQ)) / (n * n));
      unique case (flt)
         ipf_pkg::F_GAUSS: resD = 8'(int'(gsQ) >> ((rad == 3'sd1) ?
            ipf_pkg::GAUSS_SHIFT_3 : ipf_pkg::GAUSS_SHIFT_5));
         ipf_pkg::F_ERODE: resD = mnQ;
         ipf_pkg::F_DILATE: resD = mxQ;
         ipf_pkg::F_MEDIAN: resD = medQ;
         ipf_pkg::F_MEAN: resD = 8'(int'(sumQ) / n);
         ipf_pkg::F_RANGE: resD = mxQ - mnQ;
         ipf_pkg::F_GAIN: resD = (g > 255) ? ipf_pkg::PIX_MAX : 8'(g);
         ipf_pkg::F_INVERT: resD = ipf_pkg::PIX_MAX - ctrQ;
         default: resD = ctrQ;
      endcase
   end

   ipf_isqrt #(.WIDTH(32)) rootUnit (
      .sys_clk(sys_clk),
      .rst(rst),
      .start(rootStart),
      .radicand(radicand),
      .done(rootDone),
      .root(rootVal)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer: capture, slot passes, output. Configuration is frozen per frame
   // so a slot cannot change filter half way through a pass.
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         stateQ <= S_IDLE;
         {xQ, yQ, slotQ, bankQ, endQ} <= '0;
         {cfgFltQ, cfgSizeQ, cfgGainQ} <= '0;
         geoQ <= ipf_pkg::G_NONE;
         outValid <= 1'b0;
         outData <= 8'h00;
         outLast <= 1'b0;
         resQ <= 8'h00;
      end
      else
      begin
         unique case (stateQ)
            S_IDLE:
            begin
               cfgFltQ <= slotFilter;
               cfgSizeQ <= slotSize;
               cfgGainQ <= slotGain;
               geoQ <= ipf_pkg::ipf_geo_e'(geoMode);
               {xQ, yQ, slotQ, bankQ, endQ} <= '0;
               stateQ <= S_LOAD;
            end
            S_LOAD:
               if (inValid)
               begin
                  xQ <= (int'(xQ) == W - 1) ? '0 : xQ + 1'b1;
                  if (int'(xQ) == W - 1)
                     yQ <= yQ + 1'b1;
                  if (lastPix)
                  begin
                     yQ <= '0;
                     stateQ <= S_SETUP;
                  end
               end
            S_SETUP:
               if (int'(slotQ) == ipf_pkg::NUM_SLOTS)
                  stateQ <= S_UNLOAD;
               else if (cfgSizeQ[slotQ] == ipf_pkg::SIZE_OFF)
                  slotQ <= slotQ + 3'h1;
               else
                  stateQ <= S_SWEEP;
            S_SWEEP:
               if (winEnd && (flt != ipf_pkg::F_MEDIAN || medBitQ == 3'h0))
                  stateQ <= S_FINISH;
            S_FINISH:
            begin
               resQ <= resD;
               stateQ <= rootStart ? S_ROOT : S_WRITE;
            end
            S_ROOT:
               if (rootDone)
               begin
                  resQ <= (rootVal > 16'h00ff) ? ipf_pkg::PIX_MAX : rootVal[7:0];
                  stateQ <= S_WRITE;
               end
            S_WRITE:
            begin
               xQ <= (int'(xQ) == W - 1) ? '0 : xQ + 1'b1;
               if (int'(xQ) == W - 1)
                  yQ <= yQ + 1'b1;
               stateQ <= S_SWEEP;
               if (lastPix)
               begin
                  yQ <= '0;
                  bankQ <= ~bankQ;
                  slotQ <= slotQ + 3'h1;
                  stateQ <= S_SETUP;
               end
            end
            S_UNLOAD:
               if (!outValid || outReady)
               begin
                  outValid <= !endQ;
                  outData <= p;
                  outLast <= lastPix;
                  endQ <= endQ | lastPix;
                  xQ <= (int'(xQ) == W - 1) ? '0 : xQ + 1'b1;
                  if (int'(xQ) == W - 1)
                     yQ <= yQ + 1'b1;
                  if (endQ)
                     stateQ <= S_IDLE;
               end
         endcase
      end
   end

   // Window walk and accumulators; the median repeats the walk once per bit.
   always_ff @(posedge sys_clk)
   begin
      if (rst || stateQ == S_SETUP || stateQ == S_WRITE)
      begin
         wxQ <= (stateQ == S_SWEEP || stateQ == S_SETUP || stateQ == S_WRITE) &&
                !rst && int'(slotQ) < ipf_pkg::NUM_SLOTS ? -rad : 3'sd0;
         wyQ <= (stateQ == S_SETUP || stateQ == S_WRITE) && !rst &&
                int'(slotQ) < ipf_pkg::NUM_SLOTS ? -rad : 3'sd0;
         mnQ <= ipf_pkg::PIX_MAX;
         {mxQ, ctrQ, medQ, ltCntQ, sumQ, sqQ, gxQ, gyQ, gsQ} <= '0;
         medBitQ <= ipf_pkg::MED_TOP_BIT;
      end
      else if (stateQ == S_SWEEP)
      begin
         mnQ <= (p < mnQ) ? p : mnQ;
         mxQ <= (p > mxQ) ? p : mxQ;
         sumQ <= sumQ + 13'(p);
         sqQ <= sqQ + 21'(int'(p) * int'(p));
         gsQ <= gsQ + 16'(binw(int'(wxQ), int'(rad)) * binw(int'(wyQ), int'(rad)) * int'(p));
         if (wxQ >= -3'sd1 && wxQ <= 3'sd1 && wyQ >= -3'sd1 && wyQ <= 3'sd1)
         begin
            gxQ <= gxQ + 12'(int'(wxQ) * (2 - ((wyQ == 3'sd0) ? 0 : 1)) * int'(p));
            gyQ <= gyQ + 12'(int'(wyQ) * (2 - ((wxQ == 3'sd0) ? 0 : 1)) * int'(p));
         end
         if (wxQ == 3'sd0 && wyQ == 3'sd0)
            ctrQ <= p;
         ltCntQ <= cntNext;
         wxQ <= (wxQ == rad) ? -rad : wxQ + 3'sd1;
         if (wxQ == rad)
            wyQ <= wyQ + 3'sd1;
         if (winEnd)
         begin
            // Keep the largest candidate with at most (n-1)/2 values below it.
            if (int'(cntNext) <= (n - 1) / 2)
               medQ <= cand;
            ltCntQ <= 5'h00;
            wyQ <= -rad;
            if (medBitQ != 3'h0)
               medBitQ <= medBitQ - 3'h1;
         end
      end
   end

   // Frame memory A holds the capture and the results of the second and fourth passes.
   always_ff @(posedge sys_clk)
   begin
      if (stateQ == S_LOAD && inValid)
         memA[loadAddr] <= inData;
      else if (stateQ == S_WRITE && bankQ)
         memA[pixAddr] <= resQ;
   end

   // Frame memory B holds the results of the first, third and fifth passes.
   always_ff @(posedge sys_clk)
   begin
      if (stateQ == S_WRITE && !bankQ)
         memB[pixAddr] <= resQ;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_invert_value: assert property (stateQ == S_FINISH && flt == ipf_pkg::F_INVERT
      |=> resQ == 8'hff - $past(ctrQ)) else $error("inversion wrong");
   a_gain_clip: assert property (stateQ == S_FINISH && flt == ipf_pkg::F_GAIN &&
      ctrQ >= 8'h80 |=> resQ == 8'hff) else $error("gain not saturated");
   a_erode_min: assert property (stateQ == S_FINISH && flt == ipf_pkg::F_ERODE
      |=> resQ == $past(mnQ) && resQ <= $past(ctrQ)) else $error("erosion wrong");
   a_dilate_max: assert property (stateQ == S_FINISH && flt == ipf_pkg::F_DILATE
      |=> resQ == $past(mxQ) && resQ >= $past(ctrQ)) else $error("dilation wrong");
   a_range_diff: assert property (stateQ == S_FINISH && flt == ipf_pkg::F_RANGE
      |=> resQ == $past(mxQ) - $past(mnQ)) else $error("range wrong");
   a_median_bounds: assert property (stateQ == S_FINISH && flt == ipf_pkg::F_MEDIAN
      |=> resQ >= $past(mnQ) && resQ <= $past(mxQ)) else $error("median out of window");
   a_mean_bounds: assert property (stateQ == S_FINISH && flt == ipf_pkg::F_MEAN
      |=> resQ >= $past(mnQ) && resQ <= $past(mxQ)) else $error("mean out of window");
   a_skip_off: assert property (stateQ == S_SETUP && int'(slotQ) < 5 &&
      cfgSizeQ[slotQ] == 2'h0 |=> stateQ == S_SETUP && slotQ == $past(slotQ) + 3'h1)
      else $error("disabled slot not skipped");
   a_slot_step: assert property ($changed(slotQ) && stateQ != S_LOAD
      |-> slotQ == $past(slotQ) + 3'h1) else $error("slot order broken");
   a_geo_rotate: assert property (stateQ == S_LOAD && geoQ == ipf_pkg::G_ROT180 &&
      xQ == '0 && yQ == '0 |-> int'(loadAddr) == N - 1) else $error("rotation wrong");
   a_out_hold: assert property (outValid && !outReady |=> outValid && $stable(outData))
      else $error("output dropped under stall");

   c_median_pass: cover property (stateQ == S_FINISH && flt == ipf_pkg::F_MEDIAN);
   c_sobel_root: cover property (stateQ == S_ROOT ##[1:20] stateQ == S_WRITE);
   c_frame_out: cover property (outValid && outReady && outLast);

endmodule : ipf_filter_chain

// ===== src/ipf_isqrt.sv
/*
 * Sequential integer square root, one result bit per clock.
 * Assumes start is a one-cycle pulse given only while idle.
 */
`timescale 1ns/1ns

module ipf_isqrt #(
   parameter int WIDTH = 32
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [WIDTH-1:0] radicand,
   output logic done,
   output logic [WIDTH/2-1:0] root
);

   logic [WIDTH-1:0] opQ, resQ, oneQ, opD, resD;
   logic [5:0] iterQ;
   logic busyQ;

   // Restoring digit step: try subtracting the next odd term.
   always_comb
   begin
      opD = opQ;
      resD = resQ >> 1;
      if (opQ >= resQ + oneQ)
      begin
         opD = opQ - (resQ + oneQ);
         resD = (resQ >> 1) + oneQ;
      end
   end

   // Iteration state; the result register only changes when done fires.
   always_ff @(posedge sys_clk)
   begin
      done <= 1'b0;
      if (rst)
      begin
         busyQ <= 1'b0;
         opQ <= '0;
         resQ <= '0;
         oneQ <= '0;
         iterQ <= 6'h00;
         root <= '0;
      end
      else if (start)
      begin
         busyQ <= 1'b1;
         opQ <= radicand;
         resQ <= '0;
         oneQ <= WIDTH'(1) << (WIDTH - 2);
         iterQ <= 6'(WIDTH / 2);
      end
      else if (busyQ)
      begin
         opQ <= opD;
         resQ <= resD;
         oneQ <= oneQ >> 2;
         iterQ <= iterQ - 6'h01;
         if (iterQ == 6'h01)
         begin
            busyQ <= 1'b0;
            done <= 1'b1;
            root <= resD[WIDTH/2-1:0];
         end
      end
   end

   a_root_latency: assert property (@(posedge sys_clk) disable iff (rst)
      start |-> ##17 done) else $error("square root did not finish in time");
   a_root_exact: assert property (@(posedge sys_clk) disable iff (rst)
      done |-> 64'(root) * 64'(root) <= 64'($past(radicand, 17)))
      else $error("square root too large");

endmodule : ipf_isqrt

// ===== src/ipf_pkg.sv
/*
 * Shared constants and types of the image pre-processing filter chain:
 * filter and rearrangement codes, kernel size codes and pixel limits.
 * Assumes only a SystemVerilog package-capable flow.
 */
package ipf_pkg;

   // Number of filter slots in the chain.
   localparam int NUM_SLOTS = 5;

   // Pixel range for 8-bit grey values.
   localparam logic [7:0] PIX_MAX = 8'hff;
   localparam logic [7:0] PIX_MIN = 8'h00;

   // Kernel size codes of a slot; the top code is treated as 5x5.
   localparam logic [1:0] SIZE_OFF = 2'h0;
   localparam logic [1:0] SIZE_3X3 = 2'h1;
   localparam logic [1:0] SIZE_5X5 = 2'h2;

   // Gaussian weight sums: 16 for 3x3 and 256 for 5x5 binomial masks.
   localparam int GAUSS_SHIFT_3 = 4;
   localparam int GAUSS_SHIFT_5 = 8;

   // Highest bit of the bitwise median search.
   localparam logic [2:0] MED_TOP_BIT = 3'h7;

   ////////////////////////////////////////////////////////////////////////////
   // Filter selection of one slot.
   typedef enum logic [3:0] {
      F_GAUSS  = 4'h0,
      F_ERODE  = 4'h1,
      F_DILATE = 4'h2,
      F_MEDIAN = 4'h3,
      F_MEAN   = 4'h4,
      F_RANGE  = 4'h5,
      F_STDDEV = 4'h6,
      F_SOBEL  = 4'h7,
      F_GAIN   = 4'h8,
      F_INVERT = 4'h9
   } ipf_filter_e;

   // Geometric rearrangement applied while the frame is captured.
   typedef enum logic [1:0] {
      G_NONE   = 2'h0,
      G_ROT180 = 2'h1,
      G_MIRROR = 2'h2,
      G_FLIP   = 2'h3
   } ipf_geo_e;

endpackage : ipf_pkg
